// ### asc_curves.v
// Behaviour
// - channel scaling enable gates any scaling
// - curve enable starts acquisition and evaluation
// - per curve selectable input source
// - optional first-order low-pass input averaging
// - filter time constant in 5 ms steps
// - range supervision optional, gates the flag
// - flag when input below min or above max
// - limits signed, unit 0.00001
// - one range flag output per curve
// - lost input holds last measured value
// - input refreshed once per update cycle
// - float, floor, ceiling or nearest rounding
// - two default points (0,0) and (1,0)
// - points 3 to 20 individually marked used
// - curve input and output readable
`timescale 1ns/1ps
`include "asc_regs.vh"
module asc_curves #(
  parameter NC = 10, // curves
  parameter NS = 32, // measurement sources
  parameter SW = 5, // source select width
  parameter W = 48, // value width
  parameter PTS = 20, // points per curve
  parameter STEP_CYC = `ASC_STEP_CYC // cycles per 5 ms step
) (
  input wire clock_i, // system clock
  input wire nrst_i, // async reset, active low
  input wire [NS*W-1:0] meas_i, // source values, signed
  input wire [NS-1:0] meas_valid_i, // source signal present
  input wire [NS-1:0] scale_en_i, // per source scaling enable
  input wire [NC-1:0] curve_en_i, // per curve enable
  input wire [NC*SW-1:0] src_sel_i, // per curve source select
  input wire [NC-1:0] filt_en_i, // per curve filter enable
  input wire [NC*20-1:0] filt_tc_i, // filter constant, 5 ms steps
  input wire [NC-1:0] range_en_i, // per curve range supervision
  input wire [NC*W-1:0] in_min_i, // per curve input minimum
  input wire [NC*W-1:0] in_max_i, // per curve input maximum
  input wire [NC*11-1:0] upd_cyc_i, // update cycle, 5 ms steps
  input wire [NC*2-1:0] rnd_mode_i, // rounding mode
  input wire [NC*(PTS-2)-1:0] pt_used_i, // points 3..20 used
  input wire pt_wr_en_i, // point write strobe
  input wire [7:0] pt_wr_addr_i, // curve*20 + point index
  input wire [W-1:0] pt_wr_in_i, // point input value
  input wire [W-1:0] pt_wr_out_i, // point output value
  output wire [NC*W-1:0] curve_in_o, // held curve input
  output wire [NC*W-1:0] curve_out_o, // scaled curve output
  output reg [NC-1:0] scaling_curve_range_flag_o // out of range
);
  // engine states
  localparam S_IDLE = 4'h0;
  localparam S_LOAD = 4'h1;
  localparam S_FILT = 4'h2;
  localparam S_RD = 4'h3;
  localparam S_CHK = 4'h4;
  localparam S_INT = 4'h5;
  localparam S_RND = 4'h6;
  localparam S_RFIX = 4'h7;
  localparam S_DONE = 4'h8;
  localparam S_DIV = 4'h9;

  // magnitude of a signed value
  function [95:0] mag96;
    input signed [95:0] v;
    begin
      mag96 = v[95] ? -v : v;
    end
  endfunction

  reg [31:0] step_cnt_reg; // 5 ms base counter
  reg step_reg; // base tick pulse
  reg [10:0] upd_cnt_reg [0:NC-1]; // steps into update cycle
  reg [NC-1:0] pend_reg; // update due
  reg [W-1:0] raw_reg [0:NC-1]; // held input
  reg [W-1:0] filt_reg [0:NC-1]; // filter state
  reg [W-1:0] out_reg [0:NC-1]; // curve output
  reg [3:0] st_reg; // engine state
  reg [3:0] ret_reg; // state after division
  reg [3:0] cur_reg; // curve served
  reg [4:0] idx_reg; // point index walked
  reg signed [W-1:0] x_reg; // working input
  reg signed [W-1:0] y_reg; // working output
  reg signed [W-1:0] pin_reg; // previous used point input
  reg signed [W-1:0] pout_reg; // previous used point output
  reg seen_reg; // a used point has passed
  reg [95:0] dnum_reg; // divider numerator magnitude
  reg [W-1:0] dden_reg; // divider denominator magnitude
  reg [95:0] dquo_reg; // quotient magnitude
  reg [W:0] drem_reg; // remainder magnitude
  reg dneg_reg; // quotient negative
  reg nneg_reg; // numerator negative
  reg [6:0] dcnt_reg; // division steps left
  integer i;

  wire [SW-1:0] sel_w = src_sel_i[cur_reg*SW +: SW];
  wire [10:0] upd_w = upd_cyc_i[cur_reg*11 +: 11];
  wire [19:0] tc_w = filt_tc_i[cur_reg*20 +: 20];
  wire [1:0] rnd_w = rnd_mode_i[cur_reg*2 +: 2];
  wire signed [W-1:0] min_w = in_min_i[cur_reg*W +: W];
  wire signed [W-1:0] max_w = in_max_i[cur_reg*W +: W];
  wire signed [W-1:0] meas_w = meas_i[sel_w*W +: W];
  wire signed [W-1:0] mrd_in_w; // memory point input
  wire signed [W-1:0] mrd_out_w; // memory point output
  wire [7:0] rd_addr_w = cur_reg * 8'd20 + {3'h0, idx_reg};
  wire used_w = (idx_reg < 5'd2) ||
    pt_used_i[cur_reg*(PTS-2) + idx_reg - 2];
  wire last_w = (idx_reg == PTS - 1);
  // signal lost or channel disabled: keep the last value
  wire take_w = meas_valid_i[sel_w] && scale_en_i[sel_w];
  wire signed [W-1:0] xnew_w = take_w ? meas_w : raw_reg[cur_reg];
  // sign-extend both sides, the filter state is stored unsigned
  wire signed [W:0] fdiff_w = {xnew_w[W-1], xnew_w} -
    {filt_reg[cur_reg][W-1], filt_reg[cur_reg]};
  wire signed [W:0] ddx_w = x_reg - pin_reg;
  wire signed [W:0] ddy_w = mrd_out_w - pout_reg;
  wire signed [W:0] dpx_w = mrd_in_w - pin_reg;
  // divider step and signed results
  wire [W:0] trial_w = {drem_reg[W-1:0], dnum_reg[95]};
  wire tfit_w = trial_w >= {1'b0, dden_reg};
  wire [95:0] qs_w = dneg_reg ? -dquo_reg : dquo_reg;
  wire signed [W-1:0] q_w = qs_w[W-1:0];
  wire rnz_w = (drem_reg != {(W+1){1'b0}});
  wire rhalf_w = ({drem_reg, 1'b0} >= {2'b00, `ASC_ONE});

  asc_pt_mem #(.CURVES(NC), .PTS(PTS), .W(W), .AW(8)) u_mem (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .wr_en_i(pt_wr_en_i),
    .wr_addr_i(pt_wr_addr_i),
    .wr_in_i(pt_wr_in_i),
    .wr_out_i(pt_wr_out_i),
    .rd_addr_i(rd_addr_w),
    .rd_in_o(mrd_in_w),
    .rd_out_o(mrd_out_w)
  );

  // read-only views of held input and output
  genvar g;
  generate
    for (g = 0; g < NC; g = g + 1) begin : g_view
      assign curve_in_o[g*W +: W] = raw_reg[g];
      assign curve_out_o[g*W +: W] = out_reg[g];
    end
  endgenerate

  // base 5 ms step tick
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      step_cnt_reg <= 32'h0;
      step_reg <= 1'b0;
    end else if (step_cnt_reg >= STEP_CYC - 1) begin
      step_cnt_reg <= 32'h0;
      step_reg <= 1'b1;
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'h1;
      step_reg <= 1'b0;
    end
  end

  // update cycle counters, a new set wins over the serve clear
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_reg <= {NC{1'b0}};
      for (i = 0; i < NC; i = i + 1) upd_cnt_reg[i] <= 11'h0;
    end else begin
      for (i = 0; i < NC; i = i + 1) begin
        if (st_reg == S_IDLE && pend_reg[i] && cur_reg == i)
          pend_reg[i] <= 1'b0;
        if (!curve_en_i[i]) begin
          upd_cnt_reg[i] <= 11'h0;
          pend_reg[i] <= 1'b0;
        end else if (step_reg) begin
          if (upd_cnt_reg[i] + 11'h1 >= upd_cyc_i[i*11 +: 11]) begin
            upd_cnt_reg[i] <= 11'h0;
            pend_reg[i] <= 1'b1;
          end else begin
            upd_cnt_reg[i] <= upd_cnt_reg[i] + 11'h1;
          end
        end
      end
    end
  end

  // serial engine: sample, filter, interpolate, round
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      cur_reg <= 4'h0;
      idx_reg <= 5'h0;
      x_reg <= {W{1'b0}};
      y_reg <= {W{1'b0}};
      pin_reg <= {W{1'b0}};
      pout_reg <= {W{1'b0}};
      seen_reg <= 1'b0;
      dnum_reg <= 96'h0;
      dden_reg <= {W{1'b0}};
      dquo_reg <= 96'h0;
      drem_reg <= {(W+1){1'b0}};
      dneg_reg <= 1'b0;
      nneg_reg <= 1'b0;
      dcnt_reg <= 7'h0;
      scaling_curve_range_flag_o <= {NC{1'b0}};
      for (i = 0; i < NC; i = i + 1) begin
        raw_reg[i] <= {W{1'b0}};
        filt_reg[i] <= {W{1'b0}};
        out_reg[i] <= {W{1'b0}};
      end
    end else begin
      for (i = 0; i < NC; i = i + 1)
        if (!curve_en_i[i] || !range_en_i[i])
          scaling_curve_range_flag_o[i] <= 1'b0;
      case (st_reg)
        S_IDLE: begin // round-robin scan, next curve when this one is not due
          if (pend_reg[cur_reg]) begin
            st_reg <= S_LOAD;
          end else begin
            cur_reg <= (cur_reg == NC - 1) ? 4'h0 : cur_reg + 4'h1;
          end
        end
        S_LOAD: begin
          if (!curve_en_i[cur_reg] || !scale_en_i[sel_w]) begin
            st_reg <= S_IDLE;
          end else begin
            raw_reg[cur_reg] <= xnew_w;
            scaling_curve_range_flag_o[cur_reg] <= range_en_i[cur_reg] &&
              (xnew_w < min_w || xnew_w > max_w);
            idx_reg <= 5'h0;
            seen_reg <= 1'b0;
            if (filt_en_i[cur_reg] && {9'h0, upd_w} < tc_w) begin
              // y += (x - y) * T / tau
              dnum_reg <= mag96($signed(fdiff_w) * $signed({1'b0, upd_w}));
              dneg_reg <= fdiff_w[W];
              nneg_reg <= fdiff_w[W];
              dden_reg <= {{(W-20){1'b0}}, tc_w};
              dquo_reg <= 96'h0;
              drem_reg <= {(W+1){1'b0}};
              dcnt_reg <= 7'd96;
              ret_reg <= S_FILT;
              st_reg <= S_DIV;
            end else begin
              filt_reg[cur_reg] <= xnew_w;
              x_reg <= xnew_w;
              st_reg <= S_RD;
            end
          end
        end
        S_FILT: begin
          filt_reg[cur_reg] <= filt_reg[cur_reg] + q_w;
          x_reg <= filt_reg[cur_reg] + q_w;
          st_reg <= S_RD;
        end
        S_RD: st_reg <= S_CHK; // memory read latency
        S_CHK: begin
          if (used_w && (!seen_reg || x_reg > mrd_in_w)) begin
            pin_reg <= mrd_in_w; // input above this point, move on
            pout_reg <= mrd_out_w;
            seen_reg <= 1'b1;
            if (last_w) begin
              y_reg <= mrd_out_w; // clamp above last point
              st_reg <= S_RND;
            end else begin
              idx_reg <= idx_reg + 5'h1;
              st_reg <= S_RD;
            end
          end else if (used_w) begin
            if (x_reg <= pin_reg || dpx_w == 0) begin
              y_reg <= (x_reg <= pin_reg) ? pout_reg : mrd_out_w;
              st_reg <= S_RND;
            end else begin
              // out = p0o + (x - p0i) * (p1o - p0o) / (p1i - p0i)
              dnum_reg <= mag96($signed(ddx_w) * $signed(ddy_w));
              dneg_reg <= ddy_w[W];
              nneg_reg <= ddy_w[W];
              dden_reg <= dpx_w[W-1:0];
              dquo_reg <= 96'h0;
              drem_reg <= {(W+1){1'b0}};
              dcnt_reg <= 7'd96;
              ret_reg <= S_INT;
              st_reg <= S_DIV;
            end
          end else if (last_w) begin
            y_reg <= pout_reg;
            st_reg <= S_RND;
          end else begin
            idx_reg <= idx_reg + 5'h1;
            st_reg <= S_RD;
          end
        end
        S_INT: begin
          y_reg <= pout_reg + q_w;
          st_reg <= S_RND;
        end
        S_RND: begin
          if (rnd_w == `ASC_RND_FLOAT) begin
            st_reg <= S_DONE;
          end else begin
            dnum_reg <= mag96(y_reg);
            dneg_reg <= y_reg[W-1];
            nneg_reg <= y_reg[W-1];
            dden_reg <= `ASC_ONE;
            dquo_reg <= 96'h0;
            drem_reg <= {(W+1){1'b0}};
            dcnt_reg <= 7'd96;
            ret_reg <= S_RFIX;
            st_reg <= S_DIV;
          end
        end
        S_RFIX: begin
          // quotient truncates toward zero, then adjust per mode
          if (rnd_w == `ASC_RND_FLOOR && nneg_reg && rnz_w)
            y_reg <= (q_w - 1) * `ASC_ONE;
          else if (rnd_w == `ASC_RND_CEIL && !nneg_reg && rnz_w)
            y_reg <= (q_w + 1) * `ASC_ONE;
          else if (rnd_w == `ASC_RND_NEAR && rhalf_w)
            y_reg <= (nneg_reg ? q_w - 1 : q_w + 1) * `ASC_ONE;
          else
            y_reg <= q_w * `ASC_ONE;
          st_reg <= S_DONE;
        end
        S_DONE: begin
          out_reg[cur_reg] <= y_reg;
          st_reg <= S_IDLE;
        end
        S_DIV: begin // restoring division, one bit per cycle
          dnum_reg <= {dnum_reg[94:0], 1'b0};
          drem_reg <= tfit_w ? trial_w - {1'b0, dden_reg} : trial_w;
          dquo_reg <= {dquo_reg[94:0], tfit_w};
          dcnt_reg <= dcnt_reg - 7'h1;
          if (dcnt_reg == 7'h1) st_reg <= ret_reg;
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
endmodule // asc_curves

// ### asc_regs.vh
`ifndef ASC_REGS_VH
`define ASC_REGS_VH
// clock period and base step of all timing settings
`define ASC_CLK_NS 10
`define ASC_STEP_NS 5000000
`define ASC_STEP_CYC (`ASC_STEP_NS / `ASC_CLK_NS)
// fixed point scale: one unit is 0.00001
`define ASC_ONE 48'sd100000
// default update cycle 150 ms and filter constant 1 s, in 5 ms steps
`define ASC_UPD_DEF 11'h01e
`define ASC_TC_DEF 20'h000c8
// point defaults: point 1 = (0,0), point 2 = (1,0)
`define ASC_P1_IN 48'h0
`define ASC_P1_OUT 48'h0
`define ASC_P2_IN 48'h0186a0
`define ASC_P2_OUT 48'h0
// rounding modes
`define ASC_RND_FLOAT 2'h0
`define ASC_RND_FLOOR 2'h1
`define ASC_RND_CEIL 2'h2
`define ASC_RND_NEAR 2'h3
`endif

// ### asc_pt_mem.v
`timescale 1ns/1ps
`include "asc_regs.vh"
// curve point store, entry = curve*PTS + point
module asc_pt_mem #(
  parameter CURVES = 10,
  parameter PTS = 20,
  parameter W = 48,
  parameter AW = 8
) (
  input wire clock_i, // system clock
  input wire nrst_i, // async reset, active low
  input wire wr_en_i, // write strobe
  input wire [AW-1:0] wr_addr_i, // write entry
  input wire [W-1:0] wr_in_i, // point input value
  input wire [W-1:0] wr_out_i, // point output value
  input wire [AW-1:0] rd_addr_i, // read entry
  output reg [W-1:0] rd_in_o, // registered input value
  output reg [W-1:0] rd_out_o // registered output value
);
  localparam DEPTH = CURVES * PTS;
  reg [W-1:0] in_mem [0:DEPTH-1]; // input values
  reg [W-1:0] out_mem [0:DEPTH-1]; // output values
  reg [DEPTH-1:0] wr_seen_reg; // entry written since reset
  wire [31:0] pt_mod; // point number, full width
  wire [AW-1:0] pt_idx; // point number inside curve
  assign pt_mod = rd_addr_i % PTS;
  assign pt_idx = pt_mod[AW-1:0];

  // storage writes, no reset on the array
  always @(posedge clock_i) begin
    if (wr_en_i) begin
      in_mem[wr_addr_i] <= wr_in_i;
      out_mem[wr_addr_i] <= wr_out_i;
    end
  end

  // written flags select defaults until software writes
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_seen_reg <= {DEPTH{1'b0}};
    end else if (wr_en_i) begin
      wr_seen_reg[wr_addr_i] <= 1'b1;
    end
  end

  // registered read with default points
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_in_o <= {W{1'b0}};
      rd_out_o <= {W{1'b0}};
    end else if (wr_seen_reg[rd_addr_i]) begin
      rd_in_o <= in_mem[rd_addr_i];
      rd_out_o <= out_mem[rd_addr_i];
    end else if (pt_idx == 0) begin
      rd_in_o <= `ASC_P1_IN;
      rd_out_o <= `ASC_P1_OUT;
    end else if (pt_idx == 1) begin
      rd_in_o <= `ASC_P2_IN;
      rd_out_o <= `ASC_P2_OUT;
    end else begin
      rd_in_o <= {W{1'b0}};
      rd_out_o <= {W{1'b0}};
    end
  end
endmodule // asc_pt_mem

// ### asc_checker_assertions.sv
`timescale 1ns/1ps
// watches curve 0 in detail and every flag for gating
module asc_checker #(
  parameter NC = 10,
  parameter NS = 32,
  parameter SW = 5,
  parameter W = 48
) (
  input wire clock_i, // system clock
  input wire nrst_i, // async reset, active low
  input wire [NS-1:0] meas_valid_i, // source present
  input wire [NS-1:0] scale_en_i, // source scaling enable
  input wire [NC-1:0] curve_en_i, // curve enable
  input wire [NC*SW-1:0] src_sel_i, // source select
  input wire [NC-1:0] range_en_i, // range supervision
  input wire [NC*W-1:0] in_min_i, // lower limits
  input wire [NC*W-1:0] in_max_i, // upper limits
  input wire [NC*2-1:0] rnd_mode_i, // rounding modes
  input wire [NC*W-1:0] curve_in_o, // held inputs
  input wire [NC*W-1:0] curve_out_o, // outputs
  input wire [NC-1:0] scaling_curve_range_flag_o // range flags
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wire signed [W-1:0] in0 = curve_in_o[W-1:0]; // curve 0 input
  wire signed [W-1:0] out0 = curve_out_o[W-1:0]; // curve 0 output
  wire [SW-1:0] sel0 = src_sel_i[SW-1:0]; // curve 0 source
  // a load of curve 0, then the quiet time before the next one
  sequence s_load; $changed(in0); endsequence
  sequence s_quiet; $stable(in0)[*8]; endsequence
  property p_spacing; s_load |=> s_quiet; endproperty
  a_spacing: assert property (p_spacing)
    else $error("curve 0 input reloaded too soon");
  property p_scale;
    s_load |-> $past(curve_en_i[0] && scale_en_i[sel0]);
  endproperty
  a_scale: assert property (p_scale)
    else $error("curve 0 loaded while scaling is off");
  property p_valid; s_load |-> $past(meas_valid_i[sel0]); endproperty
  a_valid: assert property (p_valid)
    else $error("curve 0 loaded from a lost source");
  property p_range_gate;
    1 |=> (scaling_curve_range_flag_o & ~$past(range_en_i)) == '0;
  endproperty
  a_range_gate: assert property (p_range_gate)
    else $error("range flag up with supervision off");
  property p_curve_gate;
    1 |=> (scaling_curve_range_flag_o & ~$past(curve_en_i)) == '0;
  endproperty
  a_curve_gate: assert property (p_curve_gate)
    else $error("range flag up on a disabled curve");
  property p_flag_rise;
    $rose(scaling_curve_range_flag_o[0]) |->
      (in0 < $signed(in_min_i[W-1:0]) || in0 > $signed(in_max_i[W-1:0]));
  endproperty
  a_flag_rise: assert property (p_flag_rise)
    else $error("range flag raised for an input inside limits");
  property p_round;
    $changed(out0) && $past(rnd_mode_i[1:0], 2) != 2'h0 |->
      out0 % 100000 == 0;
  endproperty
  a_round: assert property (p_round)
    else $error("integer mode output has a fraction");
  property p_reset;
    $rose(nrst_i) |-> curve_out_o == '0 && curve_in_o == '0 &&
      scaling_curve_range_flag_o == '0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not clear after reset");
endmodule // asc_checker
bind asc_curves asc_checker #(.NC(NC), .NS(NS), .SW(SW), .W(W)) chk_u (.*);

// ### asc_meas_model.sv
`timescale 1ns/1ps
// measurement channels: every source shows the same value
module asc_meas_model (
  input wire clock_i, // system clock
  input wire nrst_i, // reset, active low
  input wire [47:0] val_i, // value to present
  input wire lost_i, // signal lost
  output logic [32*48-1:0] meas_o, // source values
  output logic [31:0] valid_o // source presence
);
  logic [47:0] last_reg; // last value shown while present
  // remember what was presented before a loss
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) last_reg <= 48'h0;
    else if (!lost_i) last_reg <= val_i;
  end
  // a lost channel shows garbage, never the held value
  assign meas_o = {32{lost_i ? ~last_reg : val_i}};
  assign valid_o = {32{~lost_i}};
endmodule // asc_meas_model

// ### test_analog_input_scaling_curves.sv
`timescale 1ns/1ps
module test_analog_input_scaling_curves;
  localparam NC = 10;
  localparam W = 48;
  localparam longint U = 64'h186a0; // one unit, 1.00000
  logic clock_i = 1'b0; // system clock
  logic nrst_i = 1'b0; // reset, active low
  wire [32*W-1:0] meas; // source values
  wire [31:0] meas_valid; // source presence
  logic [31:0] scale_en = '0; // scaling enables
  logic [NC-1:0] curve_en = '0; // curve enables
  logic [NC*5-1:0] src_sel = '0; // all curves on source 0
  logic [NC-1:0] filt_en = '0; // filters off
  logic [NC*20-1:0] filt_tc = {NC{20'h000c8}}; // 1 s
  logic [NC-1:0] range_en = '0; // supervision enables
  logic [NC*W-1:0] in_min = '0; // lower limits
  logic [NC*W-1:0] in_max = '0; // upper limits
  logic [NC*11-1:0] upd_cyc = {NC{11'h001}}; // one step
  logic [NC*2-1:0] rnd_mode = '0; // rounding modes
  logic [NC*18-1:0] pt_used = '0; // two-point curves
  logic wr_en = 1'b0; // point write strobe
  logic [7:0] wr_addr = 8'h00; // point entry
  logic [W-1:0] wr_in = '0; // point input
  logic [W-1:0] wr_out = '0; // point output
  logic [W-1:0] val = '0; // value the model presents
  logic lost = 1'b0; // model signal loss
  wire [NC*W-1:0] cin; // held inputs
  wire [NC*W-1:0] cout; // outputs
  wire [NC-1:0] flag; // range flags
  int num_errors = 0; // mismatches
  int comparisons = 0; // checks made
  logic [15:0] rnd = 16'h0062; // lfsr state
  longint x; // current input value
  longint y; // expected filter state
  always #5 clock_i = ~clock_i;
  asc_meas_model meas_u (.clock_i(clock_i), .nrst_i(nrst_i), .val_i(val),
    .lost_i(lost), .meas_o(meas), .valid_o(meas_valid));
  asc_curves #(.STEP_CYC(10)) dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
    .meas_i(meas), .meas_valid_i(meas_valid), .scale_en_i(scale_en),
    .curve_en_i(curve_en), .src_sel_i(src_sel), .filt_en_i(filt_en),
    .filt_tc_i(filt_tc), .range_en_i(range_en), .in_min_i(in_min),
    .in_max_i(in_max), .upd_cyc_i(upd_cyc), .rnd_mode_i(rnd_mode),
    .pt_used_i(pt_used), .pt_wr_en_i(wr_en), .pt_wr_addr_i(wr_addr),
    .pt_wr_in_i(wr_in), .pt_wr_out_i(wr_out), .curve_in_o(cin),
    .curve_out_o(cout), .scaling_curve_range_flag_o(flag));
  // next pseudo random state
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // curve (0,0)-(1,10), clamped above, then rounded
  function automatic longint expv(longint v, logic [1:0] m);
    longint y;
    y = (v > U) ? 10 * U : 10 * v;
    case (m)
      2'h1: y = y / U * U;
      2'h2: y = (y + U - 1) / U * U;
      2'h3: y = (y + U / 2) / U * U;
      default: y = y;
    endcase
    return y;
  endfunction
  // compare and count
  task automatic chk(logic [W-1:0] got, longint e);
    comparisons++;
    if (got !== e[W-1:0]) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, e[W-1:0]);
    end
  endtask
  // let several serves of curve 0 pass
  task automatic settle;
    repeat (700) @(posedge clock_i);
    #1;
  endtask
  // present a new value and let it be served
  task automatic apply(longint v);
    @(posedge clock_i) val <= v[W-1:0];
    settle;
  endtask
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #500000;
    num_errors++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i) #1;
    chk(cout[W-1:0], 0);
    chk({38'h0, flag}, 0);
    // point 2 of curve 0 becomes (1.0, 10.0)
    @(posedge clock_i) wr_en <= 1'b1;
    wr_addr <= 8'h01;
    wr_in <= 48'h0186a0;
    wr_out <= 48'h0f4240;
    @(posedge clock_i) wr_en <= 1'b0;
    curve_en[0] <= 1'b1;
    apply(64'h5);
    chk(cin[W-1:0], 0);
    scale_en[0] <= 1'b1;
    // corners first, then random inputs
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      x = (i == 0) ? 0 : (i == 1) ? U : 2 * longint'(rnd);
      apply(x);
      chk(cin[W-1:0], x);
      chk(cout[W-1:0], expv(x, 2'h0));
    end
    x = 64'h3039;
    apply(x);
    for (int m = 0; m < 4; m++) begin
      @(posedge clock_i) rnd_mode[1:0] <= m[1:0];
      settle;
      chk(cout[W-1:0], expv(x, m[1:0]));
    end
    in_min[W-1:0] <= 48'h4e20;
    in_max[W-1:0] <= 48'hc350;
    range_en[0] <= 1'b1;
    // below, inside, at the top limit, above
    for (int i = 0; i < 4; i++) begin
      x = 64'h2710 + i * 64'h4e20;
      apply(x);
      chk({47'h0, flag[0]}, (x < 64'h4e20 || x > 64'hc350) ? 1 : 0);
    end
    @(posedge clock_i) range_en[0] <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    chk({47'h0, flag[0]}, 0);
    @(posedge clock_i) lost <= 1'b1;
    apply(64'h1234);
    chk(cin[W-1:0], x);
    @(posedge clock_i) lost <= 1'b0;
    scale_en[0] <= 1'b0;
    apply(64'h3000);
    chk(cin[W-1:0], x);
    @(posedge clock_i) scale_en[0] <= 1'b1;
    range_en[0] <= 1'b1;
    apply(x);
    chk({47'h0, flag[0]}, 1);
    @(posedge clock_i) curve_en[0] <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    chk({47'h0, flag[0]}, 0);
    // filter with tau of two steps, one step update, float output
    filt_tc[19:0] <= 20'h00002;
    filt_en[0] <= 1'b1;
    rnd_mode[1:0] <= 2'h0;
    range_en[0] <= 1'b0;
    curve_en[0] <= 1'b1;
    y = x;
    repeat (24) y = y + (x + 1000 - y) / 2;
    apply(x + 1000);
    repeat (4) settle;
    chk(cin[W-1:0], x + 1000);
    chk(cout[W-1:0], expv(y, 2'h0));
    test_done;
  end
endmodule // test_analog_input_scaling_curves
